// ==== msc_pkg.sv ====
// Shared constants, states and pin bundle of the module sideband control.
`default_nettype none
package msc_pkg;
  // System clock period.
  localparam int CLK_PERIOD_NS = 100;
  // Host-side select timing: not enforced by the module. [RQ4] [RQ5] [RQ19]
  localparam int T_SEL_ASSERT_NS = 2000;
  localparam int T_SEL_DEASSERT_NS = 2000;
  localparam int SEL_ASSERT_CYC = (T_SEL_ASSERT_NS + CLK_PERIOD_NS - 1) /
                                  CLK_PERIOD_NS;
  localparam int SEL_DEASSERT_CYC = (T_SEL_DEASSERT_NS + CLK_PERIOD_NS - 1) /
                                    CLK_PERIOD_NS;
  // Least reset pulse rounds up, completion time is a bound so rounds down.
  localparam int T_RESET_PULSE_MIN_NS = 10000;
  localparam int T_RESET_COMPLETE_NS = 200000;
  localparam int RESET_PULSE_MIN_CYC = (T_RESET_PULSE_MIN_NS +
                                        CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_COMPLETE_CYC = T_RESET_COMPLETE_NS / CLK_PERIOD_NS;
  // Management port address and byte offsets.
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [6:0] ID_OFS = 7'h00;
  localparam logic [6:0] STATUS_OFS = 7'h02;
  localparam logic [6:0] FLAG_OFS = 7'h03;
  localparam logic [6:0] PWR_CTRL_OFS = 7'h5d;
  // Field positions.
  localparam int INIT_PEND_BIT = 0;
  localparam int INT_STATE_BIT = 1;
  localparam int FAULT_FLAG_BIT = 0;
  localparam int PWR_SW_CTL_BIT = 0;
  localparam int PWR_LIM_LOW_BIT = 1;
  // Reset values.
  localparam logic [7:0] PWR_CTRL_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] MEM_RST = 8'h00;
  // Identifier byte; the value is arbitrary.
  localparam logic [7:0] ID_CODE = 8'h5a;

  typedef enum logic [3:0] {
    MSC_IDLE, MSC_ADDR, MSC_ACK_ADDR, MSC_PTR, MSC_ACK_PTR,
    MSC_WR, MSC_ACK_WR, MSC_RD, MSC_RD_ACK
  } msc_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sel_n;
    logic rst_n;
    logic lp_req;
  } msc_pins_t;

  // Undriven pins settle high: bias on select, reset and low power.
  localparam msc_pins_t PINS_IDLE = 5'h1f;
endpackage
`default_nettype wire

// ==== msc_sync2.sv ====
// Two flip-flop synchroniser for a bundle of pin levels.
`default_nettype none
module msc_sync2 import msc_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== msc_timer.sv ====
// One-shot interval timer: a start pulse, busy while running, a done pulse.
`default_nettype none
module msc_timer import msc_pkg::*; #(
  parameter int CYCLES = 1
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  logic [15:0] count;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= 16'h0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        count <= 16'(CYCLES - 1);
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (count == 16'h0000) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count - 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== msc_sideband.sv ====
// Sideband control of a pluggable module: select, reset, power, interrupt.
//
// Summary of operation
// (RQ1) Selected module answers management bus commands.
// (RQ2) Deselected module never acknowledges bus traffic.
// (RQ3) Select input biased high when undriven.
// (RQ4) Host waits deassert interval after deselecting.
// (RQ5) Host waits assert interval before talking.
// (RQ6) Reset input pulled up, inactive undriven.
// (RQ7) Long reset low restores every default setting.
// (RQ8) Completion interval starts at reset release.
// (RQ9) Host ignores status until reset completes.
// (RQ10) Completion: interrupt low, init pending cleared.
// (RQ11) Power-up posts completion interrupt unprompted.
// (RQ12) Low power input pulled up, high means low.
// (RQ13) Power controls in byte 93, bits 0, 1.
// (RQ14) Power class from pin or software bits.
// (RQ15) Presence output tied low inside module.
// (RQ16) Interrupt flags faults; host reads source.
// (RQ17) Interrupt output only pulls low.
// (RQ18) Interrupt released after status and flag reads.
// (RQ19) Select and reset durations are parameters.
`default_nettype none
module msc_sideband import msc_pkg::*; #(
  parameter int RESET_PULSE_MIN = RESET_PULSE_MIN_CYC,
  parameter int RESET_COMPLETE = RESET_COMPLETE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic module_select_n_i,
  input wire logic module_reset_n_i,
  input wire logic low_power_request_i,
  input wire logic fault_event_i,
  output logic interrupt_n_o,
  output logic interrupt_n_oe_o,
  output logic presence_detect_n_o,
  output logic presence_detect_n_oe_o,
  output logic power_low_o
);
  msc_pins_t pins_raw;
  msc_pins_t pins_s;
  msc_pins_t pins_d;
  msc_state_t state;
  logic scl_rise, scl_fall, start, stop, sel, bus_ok;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [7:0] tx_next;
  logic [6:0] ptr;
  logic rw, nak;
  logic wr_stb, rd_stb;
  logic [6:0] wr_addr;
  logic [6:0] rd_addr;
  logic [7:0] wr_data;
  logic [7:0] mem [0:127];
  logic [15:0] rst_low_cnt;
  logic rst_hold, rst_release, pwrup_pend;
  logic tmr_busy, tmr_done;
  logic init_pending, reset_done_int, status_seen;
  logic [7:0] flags;
  logic [7:0] pwr_ctrl;
  logic int_act;

  assign pins_raw = {scl_i, sda_i, module_select_n_i, module_reset_n_i,
                     low_power_request_i};

  // Flops reset high, so an undriven pin reads as its idle level.
  msc_sync2 #(
    .W($bits(msc_pins_t)),
    .RST_VAL(PINS_IDLE) // [RQ3] [RQ6] [RQ12]
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pins_d <= PINS_IDLE;
    end else begin
      pins_d <= pins_s;
    end
  end

  assign scl_rise = pins_s.scl & ~pins_d.scl;
  assign scl_fall = ~pins_s.scl & pins_d.scl;
  assign start = pins_s.scl & pins_d.scl & pins_d.sda & ~pins_s.sda;
  assign stop = pins_s.scl & pins_d.scl & ~pins_d.sda & pins_s.sda;
  assign sel = ~pins_s.sel_n;
  // The bus is also shut out while a reset is being held.
  assign bus_ok = sel & ~rst_hold;

  // Read view of the lower page; live bytes override the array.
  function automatic logic [7:0] rd_byte(input logic [6:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == STATUS_OFS) begin
      r[INIT_PEND_BIT] = init_pending;
      r[INT_STATE_BIT] = int_act;
    end else if (a == FLAG_OFS) begin
      r = flags; // [RQ16]
    end else if (a == PWR_CTRL_OFS) begin
      r = pwr_ctrl;
    end else if (a == ID_OFS) begin
      r = ID_CODE;
    end else begin
      r = mem[a];
    end
    return r;
  endfunction

  assign tx_next = rd_byte(ptr);
  assign sda_o = 1'b0;

  // Management bus slave, sampled on detected clock edges.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= MSC_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= 7'h00;
      rw <= 1'b0;
      nak <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      wr_addr <= 7'h00;
      rd_addr <= 7'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (!bus_ok || stop) begin
        state <= MSC_IDLE; // [RQ2]
        sda_oe_o <= 1'b0; // [RQ2]
      end else if (start) begin
        state <= MSC_ADDR; // [RQ1]
        bit_cnt <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        shreg <= {shreg[6:0], pins_s.sda};
        bit_cnt <= bit_cnt + 4'h1;
        if (state == MSC_RD_ACK) begin
          nak <= pins_s.sda;
        end
      end else if (scl_fall) begin
        case (state)
          MSC_ADDR: begin
            if (bit_cnt == 4'h8) begin
              if (shreg[7:1] == DEV_ADDR) begin
                state <= MSC_ACK_ADDR; // [RQ1]
                rw <= shreg[0];
                sda_oe_o <= 1'b1;
              end else begin
                state <= MSC_IDLE;
              end
            end
          end
          MSC_ACK_ADDR: begin
            bit_cnt <= 4'h0;
            if (rw) begin
              tx <= tx_next;
              sda_oe_o <= ~tx_next[7];
              rd_stb <= 1'b1;
              rd_addr <= ptr;
              ptr <= ptr + 7'h01;
              state <= MSC_RD;
            end else begin
              sda_oe_o <= 1'b0;
              state <= MSC_PTR;
            end
          end
          MSC_PTR: begin
            if (bit_cnt == 4'h8) begin
              ptr <= shreg[6:0];
              sda_oe_o <= 1'b1;
              state <= MSC_ACK_PTR;
            end
          end
          MSC_ACK_PTR, MSC_ACK_WR: begin
            sda_oe_o <= 1'b0;
            bit_cnt <= 4'h0;
            state <= MSC_WR;
          end
          MSC_WR: begin
            if (bit_cnt == 4'h8) begin
              wr_stb <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr <= ptr + 7'h01;
              sda_oe_o <= 1'b1;
              state <= MSC_ACK_WR;
            end
          end
          MSC_RD: begin
            if (bit_cnt == 4'h8) begin
              sda_oe_o <= 1'b0;
              state <= MSC_RD_ACK;
            end else begin
              sda_oe_o <= ~tx[3'h7 - bit_cnt[2:0]];
            end
          end
          MSC_RD_ACK: begin
            if (nak) begin
              state <= MSC_IDLE;
            end else begin
              tx <= tx_next;
              sda_oe_o <= ~tx_next[7];
              bit_cnt <= 4'h0;
              rd_stb <= 1'b1;
              rd_addr <= ptr;
              ptr <= ptr + 7'h01;
              state <= MSC_RD;
            end
          end
          default: begin
            state <= MSC_IDLE;
          end
        endcase
      end
    end
  end

  // General user bytes; a held reset restores their defaults.
  always_ff @(posedge clk_sys_i) begin
    if (rst_hold) begin
      for (int i = 0; i < 128; i++) begin
        mem[i] <= MEM_RST; // [RQ7]
      end
    end else if (wr_stb) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Reset pin must stay low past the least pulse before it counts.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_low_cnt <= 16'h0000;
      rst_hold <= 1'b0;
    end else if (!pins_s.rst_n) begin
      if (rst_low_cnt != 16'(RESET_PULSE_MIN)) begin
        rst_low_cnt <= rst_low_cnt + 16'h0001;
      end else begin
        rst_hold <= 1'b1; // [RQ7]
      end
    end else begin
      rst_low_cnt <= 16'h0000;
      rst_hold <= 1'b0;
    end
  end

  assign rst_release = rst_hold & pins_s.rst_n; // [RQ8]

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwrup_pend <= 1'b1;
    end else begin
      pwrup_pend <= 1'b0; // [RQ11]
    end
  end

  msc_timer #(
    .CYCLES(RESET_COMPLETE) // [RQ19]
  ) u_done_tmr (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .start_i(rst_release | pwrup_pend), // [RQ8] [RQ11]
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  // Reset completion flag and its interrupt, with the release sequence.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      init_pending <= 1'b1;
      reset_done_int <= 1'b0;
      status_seen <= 1'b0;
    end else if (rst_hold) begin
      init_pending <= 1'b1; // [RQ7]
      reset_done_int <= 1'b0;
      status_seen <= 1'b0;
    end else if (tmr_done) begin
      init_pending <= 1'b0; // [RQ10]
      reset_done_int <= 1'b1; // [RQ10]
      status_seen <= 1'b0;
    end else if (rd_stb) begin
      if (rd_addr == STATUS_OFS && !init_pending && reset_done_int) begin
        status_seen <= 1'b1; // [RQ18]
      end else if (rd_addr == FLAG_OFS && status_seen) begin
        reset_done_int <= 1'b0; // [RQ18]
        status_seen <= 1'b0;
      end
    end
  end

  // Fault flags are sticky and clear on read; a new fault wins the clear.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags <= FLAG_RST;
    end else if (rst_hold) begin
      flags <= FLAG_RST;
    end else begin
      if (rd_stb && rd_addr == FLAG_OFS) begin
        flags <= FLAG_RST;
      end
      if (fault_event_i) begin
        flags[FAULT_FLAG_BIT] <= 1'b1; // [RQ16]
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwr_ctrl <= PWR_CTRL_RST;
    end else if (rst_hold) begin
      pwr_ctrl <= PWR_CTRL_RST; // [RQ7]
    end else if (wr_stb && wr_addr == PWR_CTRL_OFS) begin
      pwr_ctrl <= wr_data; // [RQ13]
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_low_o <= 1'b1;
    end else if (pwr_ctrl[PWR_SW_CTL_BIT]) begin
      power_low_o <= pwr_ctrl[PWR_LIM_LOW_BIT]; // [RQ14]
    end else begin
      power_low_o <= pins_s.lp_req; // [RQ12] [RQ14]
    end
  end

  assign int_act = reset_done_int | (|flags);

  // Interrupt only ever sinks current; the host board supplies the high.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      interrupt_n_oe_o <= 1'b0;
    end else begin
      interrupt_n_oe_o <= int_act; // [RQ16] [RQ17]
    end
  end

  assign interrupt_n_o = 1'b0; // [RQ17]
  assign presence_detect_n_o = 1'b0; // [RQ15]
  assign presence_detect_n_oe_o = 1'b1; // [RQ15]

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  chk_desel_quiet: assert property ((!sel)[*2] |-> !sda_oe_o) // [RQ2]
    else $error("Deselected module drives the data line.");
  chk_sel_start: assert property (start && bus_ok |=> state == MSC_ADDR) // [RQ1]
    else $error("Selected module ignored a start.");
  chk_reset_defaults: assert property (rst_hold |=> init_pending && // [RQ7]
    pwr_ctrl == PWR_CTRL_RST && flags == FLAG_RST)
    else $error("Held reset did not restore defaults.");
  chk_release_timer: assert property (rst_release |=> tmr_busy) // [RQ8]
    else $error("Completion timer did not start at release.");
  chk_done_int: assert property ($fell(init_pending) |=> // [RQ10]
    interrupt_n_oe_o && !init_pending)
    else $error("Reset completion not signalled.");
  chk_powerup_post: assert property (pwrup_pend |=> tmr_busy) // [RQ11]
    else $error("Power-up completion timer did not start.");
  chk_ctrl_write: assert property (wr_stb && wr_addr == PWR_CTRL_OFS && // [RQ13]
    !rst_hold |=> pwr_ctrl == $past(wr_data))
    else $error("Power control byte not written.");
  chk_power_class: assert property (1'b1 |=> power_low_o == // [RQ14]
    ($past(pwr_ctrl[PWR_SW_CTL_BIT]) ? $past(pwr_ctrl[PWR_LIM_LOW_BIT]) :
    $past(pins_s.lp_req)))
    else $error("Wrong power class.");
  chk_fault_int: assert property (fault_event_i && !rst_hold ##1 // [RQ16]
    !rst_hold |=> interrupt_n_oe_o)
    else $error("Fault did not raise the interrupt.");
  chk_int_sink: assert property (interrupt_n_oe_o |-> !interrupt_n_o && // [RQ17]
    presence_detect_n_oe_o && !presence_detect_n_o) // [RQ15]
    else $error("Open-drain output drives high.");
  chk_int_release: assert property (rd_stb && rd_addr == FLAG_OFS && // [RQ18]
    status_seen && !rst_hold && !tmr_done |=> !reset_done_int)
    else $error("Interrupt not released after reads.");

  cov_ctrl_write: cover property (wr_stb && wr_addr == PWR_CTRL_OFS);
  cov_release: cover property ($fell(reset_done_int));
  cov_pin_reset: cover property (rst_release);
  cov_read_ack: cover property (state == MSC_RD_ACK && !nak && scl_fall);
endmodule
`default_nettype wire

// ==== msc_host_model.sv ====
// Host board model: 2-wire master, sideband pin drivers and pull-ups.
`default_nettype none
module msc_host_model import msc_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic sda_oe_i,
  output msc_pins_t pins_o,
  output logic res_v_o,
  output logic [7:0] res_d_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_q, sda_low, sel_q, rst_q, lp_q;
  // The data wire has a pull-up, so a released line reads high.
  assign pins_o = '{scl: scl_q, sda: ~(sda_low | sda_oe_i), sel_n: sel_q,
                    rst_n: rst_q, lp_req: lp_q};
  initial begin
    scl_q = 1'b1;
    sda_low = 1'b0;
    sel_q = PINS_IDLE.sel_n;
    rst_q = PINS_IDLE.rst_n;
    lp_q = PINS_IDLE.lp_req;
    res_v_o = 1'b0;
    res_d_o = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // The bus clock stands high between frames; each phase lasts 4 cycles.
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_low <= ~b;
    tick(3);
    scl_q <= 1'b1;
    tick(2);
    r = pins_o.sda;
    tick(2);
    scl_q <= 1'b0;
  endtask
  task automatic report(input logic [7:0] d);
    res_d_o <= d;
    res_v_o <= 1'b1;
    tick(1);
    res_v_o <= 1'b0;
  endtask
  task automatic start_c();
    tick(1);
    sda_low <= 1'b0;
    tick(3);
    scl_q <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl_q <= 1'b0;
  endtask
  task automatic stop_c();
    tick(1);
    sda_low <= 1'b1;
    tick(3);
    scl_q <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask
  task automatic wr_byte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    report({7'h00, r});
  endtask
  task automatic rd_byte(input logic last);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    report(d);
    bit_io(last, r);
  endtask
  // Select changes are followed by the host's own settling wait.
  task automatic select(input logic s);
    tick(1);
    sel_q <= s;
    tick(s ? SEL_DEASSERT_CYC : SEL_ASSERT_CYC);
  endtask
  task automatic rst_pulse(input int n);
    tick(1);
    rst_q <= 1'b0;
    tick(n);
    rst_q <= 1'b1;
  endtask
  task automatic set_lp(input logic l);
    tick(1);
    lp_q <= l;
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench of the module sideband control.
`default_nettype none
module tb import msc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PMIN = 4;
  localparam int PDONE = 400;
  logic clk_sys_i, sys_rst_i, fault_event_i, res_v, sda_oe;
  logic int_n, int_oe, prs_n, prs_oe, pwr_low, sda_v;
  logic [7:0] res_d;
  msc_pins_t pins;
  logic [7:0] exp_q[$];
  int err_total, checks_done;
  msc_host_model u_msc_host_model (.clk_sys_i(clk_sys_i), .sda_oe_i(sda_oe),
    .pins_o(pins), .res_v_o(res_v), .res_d_o(res_d));
  msc_sideband #(.RESET_PULSE_MIN(PMIN), .RESET_COMPLETE(PDONE))
  u_msc_sideband (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .scl_i(pins.scl), .sda_i(pins.sda), .sda_o(sda_v), .sda_oe_o(sda_oe),
    .module_select_n_i(pins.sel_n), .module_reset_n_i(pins.rst_n),
    .low_power_request_i(pins.lp_req), .fault_event_i(fault_event_i),
    .interrupt_n_o(int_n), .interrupt_n_oe_o(int_oe),
    .presence_detect_n_o(prs_n), .presence_detect_n_oe_o(prs_oe),
    .power_low_o(pwr_low));
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fail(input string w, input logic [7:0] e, s);
    err_total++;
    $display("CHECK FAILED %s expected %h seen %h", w, e, s);
  endtask
  task automatic cmp_byte(input logic [7:0] e, s);
    checks_done++;
    if (s !== e) fail("bus byte", e, s);
  endtask
  task automatic cmp_pin(input string w, input logic e, s);
    #1;
    checks_done++;
    if (s !== e) fail(w, {7'h00, e}, {7'h00, s});
  endtask
  // Acks and read bytes are checked in the order they were announced.
  always @(posedge clk_sys_i) begin
    if (res_v === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected byte", 8'h00, res_d);
      else cmp_byte(exp_q.pop_front(), res_d);
    end
  end
  task automatic acc(input logic [6:0] a, input logic wr, input logic [7:0] d);
    repeat (3) exp_q.push_back(8'h00);
    u_msc_host_model.start_c();
    u_msc_host_model.wr_byte({DEV_ADDR, 1'b0});
    u_msc_host_model.wr_byte({1'b0, a});
    if (wr) u_msc_host_model.wr_byte(d);
    else begin
      exp_q.push_back(d);
      u_msc_host_model.start_c();
      u_msc_host_model.wr_byte({DEV_ADDR, 1'b1});
      u_msc_host_model.rd_byte(1'b1);
    end
    u_msc_host_model.stop_c();
  endtask
  task automatic nak_addr(input logic [6:0] dev);
    exp_q.push_back(8'h01);
    u_msc_host_model.start_c();
    u_msc_host_model.wr_byte({dev, 1'b0});
    u_msc_host_model.stop_c();
  endtask
  // Waits are bounded so a stuck interrupt cannot hang the run.
  task automatic wait_int(input logic lvl, input int lim, output int n);
    n = 0;
    while (int_oe !== lvl && n < lim) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (int_oe !== lvl) begin
      fail("interrupt wait", {7'h00, lvl}, {7'h00, int_oe});
      end_of_test();
    end
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    int n;
    logic [7:0] v;
    logic sw, lim, lpv;
    err_total = 0;
    checks_done = 0;
    sys_rst_i = 1'b1;
    fault_event_i = 1'b0;
    void'($urandom(32'h549ca4d8));
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    cmp_pin("presence level", 1'b0, prs_n);
    cmp_pin("presence drive", 1'b1, prs_oe);
    cmp_pin("interrupt level", 1'b0, int_n);
    cmp_pin("interrupt early", 1'b0, int_oe);
    cmp_pin("data level", 1'b0, sda_v);
    u_msc_host_model.select(1'b0);
    acc(STATUS_OFS, 1'b0, 8'h01);
    wait_int(1'b1, PDONE, n);
    acc(STATUS_OFS, 1'b0, 8'h02);
    cmp_pin("interrupt held", 1'b1, int_oe);
    acc(FLAG_OFS, 1'b0, FLAG_RST);
    wait_int(1'b0, 20, n);
    for (int k = 0; k < 4; k++) begin
      sw = k[1];
      lim = sw ? k[0] : 1'($urandom_range(1));
      lpv = sw ? 1'($urandom_range(1)) : k[0];
      u_msc_host_model.set_lp(lpv);
      v = 8'h00;
      v[PWR_SW_CTL_BIT] = sw;
      v[PWR_LIM_LOW_BIT] = lim;
      acc(PWR_CTRL_OFS, 1'b1, v);
      u_msc_host_model.tick(6);
      cmp_pin("power class", k[0], pwr_low);
      acc(PWR_CTRL_OFS, 1'b0, v);
    end
    v = 8'($urandom_range(255));
    acc(7'h10, 1'b1, v);
    u_msc_host_model.rst_pulse(PMIN + 6);
    wait_int(1'b1, PDONE + 12, n);
    cmp_pin("completion start", 1'b1, n >= PDONE);
    acc(PWR_CTRL_OFS, 1'b0, PWR_CTRL_RST);
    acc(7'h10, 1'b0, MEM_RST);
    acc(STATUS_OFS, 1'b0, 8'h02);
    acc(FLAG_OFS, 1'b0, FLAG_RST);
    wait_int(1'b0, 20, n);
    acc(7'h10, 1'b1, v);
    u_msc_host_model.rst_pulse(2);
    acc(7'h10, 1'b0, v);
    u_msc_host_model.select(1'b1);
    nak_addr(DEV_ADDR);
    u_msc_host_model.select(1'b0);
    acc(ID_OFS, 1'b0, ID_CODE);
    nak_addr(DEV_ADDR ^ 7'h01);
    @(posedge clk_sys_i);
    fault_event_i <= 1'b1;
    @(posedge clk_sys_i);
    fault_event_i <= 1'b0;
    wait_int(1'b1, 10, n);
    v = 8'h00;
    v[FAULT_FLAG_BIT] = 1'b1;
    acc(FLAG_OFS, 1'b0, v);
    u_msc_host_model.tick(4);
    cmp_pin("interrupt level end", 1'b0, int_n);
    cmp_pin("presence level end", 1'b0, prs_n);
    cmp_pin("all bytes seen", 1'b1, exp_q.size() == 0);
    end_of_test();
  end
endmodule
`default_nettype wire
